// [rtl/srb_pkg.sv]
package srb_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_RSC = 5'h00;
  localparam logic [4:0] OFS_BDC = 5'h04;
  localparam logic [4:0] OFS_DLO = 5'h08;
  localparam logic [4:0] OFS_DHI = 5'h0C;
  localparam logic [4:0] OFS_BUF = 5'h10;
  localparam logic [4:0] OFS_MODE = 5'h14;
  localparam logic [4:0] OFS_STAT = 5'h18;
  // receive_status_control writable fields
  localparam int PEN_BIT = 7;
  localparam int NINE_BIT = 6;
  localparam int SRE_BIT = 5;
  localparam int CRE_BIT = 4;
  localparam int ADE_BIT = 3;
  // baud_control writable fields
  localparam int ABO_BIT = 7;
  localparam int DRP_BIT = 5;
  localparam int CTP_BIT = 4;
  localparam int WDS_BIT = 3;
  localparam int WKE_BIT = 1;
  localparam int ABE_BIT = 0;
  // Mode register fields
  localparam int SYN_BIT = 0;
  localparam int MST_BIT = 1;
  localparam int HSS_BIT = 2;
  // Divide multipliers per bit time
  localparam logic [6:0] MUL_SLOW = 7'h40;
  localparam logic [6:0] MUL_MID = 7'h10;
  localparam logic [6:0] MUL_FAST = 7'h04;
  // Character lengths
  localparam logic [3:0] BITS8 = 4'h8;
  localparam logic [3:0] BITS9 = 4'h9;
  // Receiver sequence
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_STOP,
    ST_ABD
  } srb_rx_state_t;
endpackage

// [rtl/srb_receive_control.sv]
`timescale 1ns/1ps
module srb_receive_control (
  input logic clk_i,
  input logic rst_i,
  input logic ce_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [4:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input logic rx_dt_i,
  input logic tx_ck_i,
  output logic tx_ck_o,
  output logic tx_ck_oe_o,
  output logic receive_interrupt_flag_o
);

  // Whole state of the block in one record
  typedef struct packed {
    logic ack;                        // Bus answer
    logic [7:0] dat;                  // Read data
    logic port_enable;
    logic nine_bit_receive_select;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic received_ninth_bit;
    logic autobaud_overflow_flag;
    logic data_receive_polarity;
    logic clock_transmit_polarity;
    logic wide_divisor_select;
    logic wakeup_enable;
    logic autobaud_enable;
    logic sync;                       // Synchronous mode
    logic master;                     // Sync clock made here
    logic high_speed_select;
    logic [7:0] divisor_low_byte;
    logic [7:0] divisor_high_byte;
    logic [7:0] receive_buffer;
    logic full;                       // Buffer holds a character
    logic receive_interrupt_flag;
    logic [15:0] tmr;                 // Baud timer
    logic [6:0] phase;                // Ticks within a bit
    logic [3:0] bits;                 // Bits shifted so far
    logic [8:0] receive_shift_register;
    srb_pkg::srb_rx_state_t st;
    logic rx_m;                       // Data pin, first stage
    logic rx_s;                       // Data pin, second stage
    logic rx_p;                       // Previous line level
    logic ck_m;                       // Clock pin, first stage
    logic ck_s;                       // Clock pin, second stage
    logic ck_p;                       // Previous clock level
    logic ck_q;                       // Generated sync clock
    logic wk;                         // Wake edge seen
    logic tx_o;
    logic tx_oe;
    logic [15:0] abd_cnt;             // Auto-baud bit length
    logic [6:0] abd_sub;              // Clocks within one unit
  } srb_state_t;

  srb_state_t s_q;
  srb_state_t s_d;

  logic line;         // Data line after polarity
  logic fall;
  logic rise;
  logic crise;        // Slave clock edges
  logic cfall;
  logic [15:0] div;   // Active divisor
  logic tick;         // Timer period end
  logic [6:0] mult;
  logic [6:0] half;
  logic samp;         // Async mid-bit sample point
  logic mtog;         // Master clock toggle point
  logic sedge;        // Sync sampling edge
  logic acc;
  logic wr;
  logic rd;
  logic [7:0] wd;
  logic async_on;
  logic sync_on;
  logic [3:0] nbits;
  logic [8:0] nsh;

  // Bit-time multiplier from mode bits and divisor width
  function automatic logic [6:0] mult_f(input logic syn,
                                        input logic hs,
                                        input logic wide);
    if (syn) begin
      return srb_pkg::MUL_FAST;
    end else if (hs) begin
      return wide ? srb_pkg::MUL_FAST : srb_pkg::MUL_MID;
    end
    return wide ? srb_pkg::MUL_MID : srb_pkg::MUL_SLOW;
  endfunction

  // Right-justify a finished shift register
  function automatic logic [8:0] align_f(input logic nine,
                                         input logic [8:0] sh);
    return nine ? sh : {1'b0, sh[8:1]};
  endfunction

  // Hand a finished character to the buffer
  function automatic srb_state_t load_f(input srb_state_t x,
                                        input logic [8:0] v,
                                        input logic fe);
    srb_state_t y;
    y = x;
    // Address filter only in async nine-bit mode
    if (x.address_detect_enable && x.nine_bit_receive_select &&
        !x.sync && !v[8]) begin
      return y;
    end
    if (x.full) begin
      // Unread character wins; the new one is lost
      y.overrun_error_flag = 1'b1;
    end else begin
      y.receive_buffer = v[7:0];
      y.received_ninth_bit = v[8];
      y.framing_error_flag = fe;
      y.full = 1'b1;
      y.receive_interrupt_flag = 1'b1;
    end
    return y;
  endfunction

  // Line views; the first synchroniser stages are never read here
  assign line = s_q.rx_s ^ s_q.data_receive_polarity;
  assign fall = s_q.rx_p & ~line;
  assign rise = ~s_q.rx_p & line;
  assign crise = ~s_q.ck_p & s_q.ck_s;
  assign cfall = s_q.ck_p & ~s_q.ck_s;

  // Baud generator decode
  assign div = s_q.wide_divisor_select ?
               {s_q.divisor_high_byte, s_q.divisor_low_byte} :
               {8'h00, s_q.divisor_low_byte};
  assign tick = (s_q.tmr == div);
  assign mult = mult_f(s_q.sync, s_q.high_speed_select,
                       s_q.wide_divisor_select);
  assign half = mult >> 1;
  assign samp = tick && (s_q.phase == half - 7'h01);
  assign mtog = tick && ((s_q.phase == half - 7'h01) ||
                         (s_q.phase == mult - 7'h01));
  // Sample when the new level equals the polarity select
  assign sedge = s_q.master ?
                 (mtog && (~s_q.ck_q == s_q.clock_transmit_polarity)) :
                 (s_q.clock_transmit_polarity ? crise : cfall);

  // Bus access decode
  assign acc = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign rd = acc & ~wb_we_i;
  assign wd = wb_dat_i[7:0];

  // Receiver enables per mode
  assign async_on = ~s_q.sync & s_q.continuous_receive_enable &
                    ~s_q.wakeup_enable & ~s_q.autobaud_enable;
  assign sync_on = s_q.sync & (s_q.continuous_receive_enable |
                   (s_q.single_receive_enable & s_q.master));
  assign nbits = s_q.nine_bit_receive_select ?
                 srb_pkg::BITS9 : srb_pkg::BITS8;
  assign nsh = {line, s_q.receive_shift_register[8:1]};

  // Next-state logic; hardware events come after
  // bus writes so a set wins over a clear
  always_comb begin
    s_d = s_q;
    s_d.ack = acc;
    // Pin synchronisers
    s_d.rx_m = rx_dt_i;
    s_d.rx_s = s_q.rx_m;
    s_d.rx_p = line;
    s_d.ck_m = tx_ck_i;
    s_d.ck_s = s_q.ck_m;
    s_d.ck_p = s_q.ck_s;
    // Free-running baud timer
    s_d.tmr = tick ? 16'h0000 : s_q.tmr + 16'h0001;
    if (tick) begin
      s_d.phase = (s_q.phase == mult - 7'h01) ? 7'h00 :
                  s_q.phase + 7'h01;
    end
    // Register reads
    if (rd) begin
      unique case (wb_adr_i)
        srb_pkg::OFS_RSC: s_d.dat = {s_q.port_enable,
          s_q.nine_bit_receive_select, s_q.single_receive_enable,
          s_q.continuous_receive_enable, s_q.address_detect_enable,
          s_q.framing_error_flag, s_q.overrun_error_flag,
          s_q.received_ninth_bit};
        srb_pkg::OFS_BDC: s_d.dat = {s_q.autobaud_overflow_flag,
          s_q.st == srb_pkg::ST_IDLE,
          s_q.data_receive_polarity, s_q.clock_transmit_polarity,
          s_q.wide_divisor_select, 1'b0, s_q.wakeup_enable,
          s_q.autobaud_enable};
        srb_pkg::OFS_DLO: s_d.dat = s_q.divisor_low_byte;
        srb_pkg::OFS_DHI: s_d.dat = s_q.divisor_high_byte;
        srb_pkg::OFS_BUF: s_d.dat = s_q.receive_buffer;
        srb_pkg::OFS_MODE: s_d.dat = {5'h00,
          s_q.high_speed_select, s_q.master, s_q.sync};
        srb_pkg::OFS_STAT: s_d.dat = {6'h00, s_q.full,
          s_q.receive_interrupt_flag};
        default: s_d.dat = 8'h00;
      endcase
      // Reading the buffer frees it and drops the flag
      if (wb_adr_i == srb_pkg::OFS_BUF) begin
        s_d.full = 1'b0;
        s_d.receive_interrupt_flag = 1'b0;
      end
    end
    // Register writes
    if (wr) begin
      unique case (wb_adr_i)
        srb_pkg::OFS_RSC: begin
          s_d.port_enable = wd[srb_pkg::PEN_BIT];
          s_d.nine_bit_receive_select = wd[srb_pkg::NINE_BIT];
          s_d.single_receive_enable = wd[srb_pkg::SRE_BIT];
          s_d.continuous_receive_enable = wd[srb_pkg::CRE_BIT];
          s_d.address_detect_enable = wd[srb_pkg::ADE_BIT];
          if (!wd[srb_pkg::CRE_BIT]) begin
            s_d.overrun_error_flag = 1'b0;
          end
        end
        srb_pkg::OFS_BDC: begin
          s_d.autobaud_overflow_flag = wd[srb_pkg::ABO_BIT];
          s_d.data_receive_polarity = wd[srb_pkg::DRP_BIT];
          s_d.clock_transmit_polarity = wd[srb_pkg::CTP_BIT];
          s_d.wide_divisor_select = wd[srb_pkg::WDS_BIT];
          s_d.wakeup_enable = wd[srb_pkg::WKE_BIT];
          s_d.autobaud_enable = wd[srb_pkg::ABE_BIT];
        end
        srb_pkg::OFS_DLO: begin
          s_d.divisor_low_byte = wd;
          s_d.tmr = 16'h0000;
          s_d.phase = 7'h00;
        end
        srb_pkg::OFS_DHI: begin
          s_d.divisor_high_byte = wd;
          s_d.tmr = 16'h0000;
          s_d.phase = 7'h00;
        end
        srb_pkg::OFS_MODE: begin
          s_d.sync = wd[srb_pkg::SYN_BIT];
          s_d.master = wd[srb_pkg::MST_BIT];
          s_d.high_speed_select = wd[srb_pkg::HSS_BIT];
        end
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end
    // Receiver and wake logic, only with the port on
    if (s_q.port_enable) begin
      // Wake-up: flag the falling edge, end on rise
      if (s_q.wakeup_enable && !s_q.sync) begin
        if (fall) begin
          s_d.receive_interrupt_flag = 1'b1;
          s_d.wk = 1'b1;
        end else if (rise && s_q.wk) begin
          s_d.wakeup_enable = 1'b0;
          s_d.wk = 1'b0;
        end
      end
      unique case (s_q.st)
        srb_pkg::ST_IDLE: begin
          s_d.bits = 4'h0;
          s_d.ck_q = s_q.clock_transmit_polarity;
          if (s_q.sync) begin
            if (sync_on) begin
              s_d.st = srb_pkg::ST_DATA;
              s_d.phase = 7'h00;
            end
          end else if (s_q.autobaud_enable && fall) begin
            s_d.st = srb_pkg::ST_ABD;
            s_d.abd_cnt = 16'h0000;
            s_d.abd_sub = 7'h00;
          end else if (async_on && fall) begin
            // Realign bit phase to the start edge
            s_d.st = srb_pkg::ST_START;
            s_d.phase = 7'h00;
          end
        end
        srb_pkg::ST_START: begin
          if (!async_on) begin
            s_d.st = srb_pkg::ST_IDLE;
          end else if (samp) begin
            // A glitch shorter than half a bit is dropped
            s_d.st = line ? srb_pkg::ST_IDLE : srb_pkg::ST_DATA;
          end
        end
        srb_pkg::ST_DATA: begin
          if (s_q.sync) begin
            if (!sync_on) begin
              s_d.st = srb_pkg::ST_IDLE;
              s_d.ck_q = s_q.clock_transmit_polarity;
            end else begin
              if (s_q.master && mtog) begin
                s_d.ck_q = ~s_q.ck_q;
              end
              if (sedge) begin
                s_d.receive_shift_register = nsh;
                s_d.bits = s_q.bits + 4'h1;
                if (s_q.bits == nbits - 4'h1) begin
                  s_d = load_f(s_d, align_f(
                    s_q.nine_bit_receive_select, nsh), 1'b0);
                  s_d.bits = 4'h0;
                  // Continuous mode keeps going
                  if (!s_q.continuous_receive_enable) begin
                    s_d.single_receive_enable = 1'b0;
                    s_d.st = srb_pkg::ST_IDLE;
                  end
                end
              end
            end
          end else if (!async_on) begin
            s_d.st = srb_pkg::ST_IDLE;
          end else if (samp) begin
            s_d.receive_shift_register = nsh;
            s_d.bits = s_q.bits + 4'h1;
            if (s_q.bits == nbits - 4'h1) begin
              s_d.st = srb_pkg::ST_STOP;
            end
          end
        end
        srb_pkg::ST_STOP: begin
          if (!async_on) begin
            s_d.st = srb_pkg::ST_IDLE;
          end else if (samp) begin
            // Low stop bit marks a framing error
            s_d = load_f(s_d, align_f(s_q.nine_bit_receive_select,
                         s_q.receive_shift_register), ~line);
            s_d.st = srb_pkg::ST_IDLE;
          end
        end
        srb_pkg::ST_ABD: begin
          // Start bit length counted in units of mult clocks
          if (!s_q.autobaud_enable || s_q.sync) begin
            s_d.st = srb_pkg::ST_IDLE;
          end else if (rise) begin
            {s_d.divisor_high_byte, s_d.divisor_low_byte} =
              (s_q.abd_cnt == 16'h0000) ? 16'h0000 :
              s_q.abd_cnt - 16'h0001;
            s_d.autobaud_enable = 1'b0;
            s_d.tmr = 16'h0000;
            s_d.st = srb_pkg::ST_IDLE;
          end else if (s_q.abd_sub == mult - 7'h01) begin
            s_d.abd_sub = 7'h00;
            s_d.abd_cnt = s_q.abd_cnt + 16'h0001;
            if (s_q.abd_cnt == 16'hFFFF) begin
              s_d.autobaud_overflow_flag = 1'b1;
              s_d.autobaud_enable = 1'b0;
              s_d.st = srb_pkg::ST_IDLE;
            end
          end else begin
            s_d.abd_sub = s_q.abd_sub + 7'h01;
          end
        end
        default: s_d.st = srb_pkg::ST_IDLE;
      endcase
    end else begin
      // Port off: receiver and its flags held in reset
      s_d.st = srb_pkg::ST_IDLE;
      s_d.full = 1'b0;
      s_d.receive_interrupt_flag = 1'b0;
      s_d.framing_error_flag = 1'b0;
      s_d.overrun_error_flag = 1'b0;
      s_d.wk = 1'b0;
      s_d.tmr = 16'h0000;
      s_d.phase = 7'h00;
      s_d.ck_q = s_q.clock_transmit_polarity;
    end
    // Pin drive; no transmitter, so async line idles
    s_d.tx_oe = s_d.port_enable &
                (~s_d.sync | s_d.master);
    s_d.tx_o = s_d.sync ? s_d.ck_q :
               ~s_d.clock_transmit_polarity;
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state record
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = {24'h000000, s_q.dat};
  assign tx_ck_o = s_q.tx_o;
  assign tx_ck_oe_o = s_q.tx_oe;
  assign receive_interrupt_flag_o = s_q.receive_interrupt_flag;

endmodule

// [verification/srb_monitor.sv]
`timescale 1ns/1ps
// Watches bus timing, pin drive and the receive flag at the top ports
module srb_monitor (
  input logic clk_i,
  input logic rst_i,
  input logic ce_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [4:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic rx_dt_i,
  input logic tx_ck_i,
  input logic tx_ck_o,
  input logic tx_ck_oe_o,
  input logic receive_interrupt_flag_o
);
  // Shadow of {enable, tx polarity, master, sync}; pin drive follows the
  // write at the same edge, so one shadow stage lines up with the pins
  typedef struct packed {
    logic [3:0] cfg;
    logic unm;
  } srb_mon_t;
  srb_mon_t s_q, s_d;
  logic take; // Request taken at this edge
  logic wr0; // Write that reaches byte lane 0
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  assign wr0 = take && wb_we_i && wb_sel_i[0];
  // Shadow of the mode bits written over the bus
  always_comb begin
    s_d = s_q;
    s_d.unm = take && !wb_we_i &&
      (wb_adr_i > srb_pkg::OFS_STAT || wb_adr_i[1:0] != 2'h0);
    if (wr0 && wb_adr_i == srb_pkg::OFS_RSC) begin
      s_d.cfg[3] = wb_dat_i[srb_pkg::PEN_BIT];
    end
    if (wr0 && wb_adr_i == srb_pkg::OFS_BDC) begin
      s_d.cfg[2] = wb_dat_i[srb_pkg::CTP_BIT];
    end
    if (wr0 && wb_adr_i == srb_pkg::OFS_MODE) begin
      s_d.cfg[1] = wb_dat_i[srb_pkg::MST_BIT];
      s_d.cfg[0] = wb_dat_i[srb_pkg::SYN_BIT];
    end
  end
  // Frozen with the design when the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    take;
  endsequence
  sequence s_rdbuf;
    take && !wb_we_i && wb_adr_i == srb_pkg::OFS_BUF;
  endsequence
  chk_ack_answer: assert property (s_take |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property ((!take && ce_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_unmapped_zero: assert property (s_q.unm |-> wb_ack_o && wb_dat_o == 0)
    else $error("unmapped read not zero");
  chk_pin_drive: assert property (
    tx_ck_oe_o == (s_q.cfg[3] && (!s_q.cfg[0] || s_q.cfg[1])))
    else $error("pin drive enable wrong");
  chk_idle_level: assert property (
    (!s_q.cfg[0] && !$past(rst_i)) |-> tx_ck_o == !s_q.cfg[2])
    else $error("transmit idle level wrong");
  chk_flag_clear: assert property (s_rdbuf |=> ##1
    !receive_interrupt_flag_o) else $error("flag kept after buffer read");
  chk_flag_hold: assert property (
    (receive_interrupt_flag_o && !take && !wb_ack_o)
    |=> receive_interrupt_flag_o) else $error("flag dropped on its own");
  chk_flag_port: assert property (
    $rose(receive_interrupt_flag_o) |-> s_q.cfg[3])
    else $error("flag raised with port off");
endmodule
bind srb_receive_control srb_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .rx_dt_i(rx_dt_i), .tx_ck_i(tx_ck_i), .tx_ck_o(tx_ck_o),
  .tx_ck_oe_o(tx_ck_oe_o),
  .receive_interrupt_flag_o(receive_interrupt_flag_o));

// [verification/srb_serial_peer.sv]
`timescale 1ns/1ps
// Remote transmitter on the receive line, one frame per call
module srb_serial_peer (
  input logic clk_i,
  output logic line_o
);
  initial line_o = 1'b1; // Idle mark level
  // Park the line at idle for a polarity
  task automatic park(input logic inv);
    @(posedge clk_i);
    line_o <= !inv;
  endtask
  // Start, data LSB first, stop; a low stop_v breaks the frame
  task automatic send(input logic [8:0] ch, input int nbits,
                      input int bclk, input logic stop_v, input logic inv);
    for (int i = 0; i < nbits + 2; i++) begin
      @(posedge clk_i);
      line_o <= inv ^ (i == 0 ? 1'b0 : (i > nbits ? stop_v : ch[i-1]));
      repeat (bclk - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    line_o <= !inv;
  endtask
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
// Register bus tasks, peer frames, one task a scenario
module testbench;
  logic clk_i, rst_i, cyc, stb, we, ack, ck_o, ck_oe, flag, line;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd_q;
  int err_total, cmp_count;
  srb_receive_control dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_dt_i(line), .tx_ck_i(1'b1), .tx_ck_o(ck_o), .tx_ck_oe_o(ck_oe),
    .receive_interrupt_flag_o(flag));
  srb_serial_peer peer (.clk_i(clk_i), .line_o(line));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Verdict and end of run
  task automatic stop_test();
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic fail(input string m);
    err_total++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e,
                          input string m);
    cmp_count++;
    if (g !== e) fail(m);
  endtask
  task automatic cmp_bit(input logic g, input logic e, input string m);
    cmp_count++;
    if (g !== e) fail(m);
  endtask
  // Classic cycle held until ack is seen at a rising edge
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      fail("no ack");
      stop_test();
    end
    rd_q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e,
                        input string m);
    bus(1'b0, a, 8'h00, 4'h1);
    cmp_byte(rd_q[7:0], e, m);
  endtask
  // Bounded wait for a loaded character
  task automatic wait_flag();
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 12000) begin
      @(posedge clk_i);
      n++;
    end
    cmp_bit(flag, 1'b1, "no receive flag");
  endtask
  // Reset values, ignored lane, unmapped place
  task automatic t_reset();
    rd_chk(srb_pkg::OFS_RSC, 8'h00, "control reset");
    rd_chk(srb_pkg::OFS_BDC, 8'h40, "idle flag reset");
    bus(1'b1, srb_pkg::OFS_RSC, 8'h90, 4'h2);
    rd_chk(srb_pkg::OFS_RSC, 8'h00, "lane write taken");
    wr(5'h1C, 8'hFF);
    rd_chk(5'h1C, 8'h00, "unmapped read");
    cmp_bit(ck_oe, 1'b0, "pin driven while off");
  endtask
  // Plain 8-bit frame, 64 clocks a bit; idle flag drops mid-frame
  task automatic t_async();
    wr(srb_pkg::OFS_DLO, 8'h00);
    wr(srb_pkg::OFS_RSC, 8'h90);
    @(negedge clk_i);
    cmp_bit(ck_oe, 1'b1, "pin not driven");
    cmp_bit(ck_o, 1'b1, "idle level high");
    fork
      peer.send(9'h0A5, 8, 64, 1'b1, 1'b0);
    join_none
    repeat (150) @(posedge clk_i);
    rd_chk(srb_pkg::OFS_BDC, 8'h00, "idle in frame");
    wait_flag();
    rd_chk(srb_pkg::OFS_RSC, 8'h90, "status good frame");
    rd_chk(srb_pkg::OFS_BUF, 8'hA5, "data byte");
    repeat (2) @(negedge clk_i);
    cmp_bit(flag, 1'b0, "flag after read");
    wait fork;
  endtask
  // Broken stop marks framing; the next good frame refreshes it
  task automatic t_frame();
    peer.send(9'h03C, 8, 64, 1'b0, 1'b0);
    wait_flag();
    rd_chk(srb_pkg::OFS_RSC, 8'h94, "framing set");
    rd_chk(srb_pkg::OFS_BUF, 8'h3C, "bad frame data");
    peer.send(9'h0C3, 8, 64, 1'b1, 1'b0);
    wait_flag();
    rd_chk(srb_pkg::OFS_RSC, 8'h90, "framing refreshed");
    rd_chk(srb_pkg::OFS_BUF, 8'hC3, "good frame data");
  endtask
  // Second frame into a full buffer; only the enable clears the flag
  task automatic t_overrun();
    peer.send(9'h011, 8, 64, 1'b1, 1'b0);
    peer.send(9'h022, 8, 64, 1'b1, 1'b0);
    rd_chk(srb_pkg::OFS_RSC, 8'h92, "overrun set");
    rd_chk(srb_pkg::OFS_BUF, 8'h11, "first byte kept");
    rd_chk(srb_pkg::OFS_RSC, 8'h92, "overrun held");
    wr(srb_pkg::OFS_RSC, 8'h80);
    rd_chk(srb_pkg::OFS_RSC, 8'h80, "overrun cleared");
  endtask
  // Nine-bit frames with address detection
  task automatic t_addr();
    wr(srb_pkg::OFS_RSC, 8'hD8);
    peer.send(9'h055, 9, 64, 1'b1, 1'b0);
    cmp_bit(flag, 1'b0, "data frame kept");
    peer.send(9'h1AA, 9, 64, 1'b1, 1'b0);
    wait_flag();
    rd_chk(srb_pkg::OFS_RSC, 8'hD9, "ninth bit");
    rd_chk(srb_pkg::OFS_BUF, 8'hAA, "address byte");
  endtask
  // Fast and wide rates, inverted line, low transmit idle
  task automatic t_rates();
    wr(srb_pkg::OFS_RSC, 8'h00);
    wr(srb_pkg::OFS_BDC, 8'h30);
    peer.park(1'b1);
    wr(srb_pkg::OFS_MODE, 8'h04);
    wr(srb_pkg::OFS_DLO, 8'h01);
    wr(srb_pkg::OFS_RSC, 8'h90);
    @(negedge clk_i);
    cmp_bit(ck_o, 1'b0, "idle level low");
    peer.send(9'h0C3, 8, 32, 1'b1, 1'b1);
    wait_flag();
    rd_chk(srb_pkg::OFS_BUF, 8'hC3, "inverted byte");
    rd_chk(srb_pkg::OFS_BDC, 8'h70, "idle before rate change");
    wr(srb_pkg::OFS_BDC, 8'h38);
    wr(srb_pkg::OFS_DHI, 8'h01);
    wr(srb_pkg::OFS_DLO, 8'h03);
    peer.send(9'h05A, 8, 1040, 1'b1, 1'b1);
    wait_flag();
    rd_chk(srb_pkg::OFS_BUF, 8'h5A, "wide divisor byte");
  endtask
  // Wake-up: a short low pulse flags, the rise clears the enable
  task automatic t_wake();
    wr(srb_pkg::OFS_RSC, 8'h00);
    wr(srb_pkg::OFS_BDC, 8'h02);
    peer.park(1'b0);
    wr(srb_pkg::OFS_MODE, 8'h00);
    wr(srb_pkg::OFS_RSC, 8'h80);
    peer.send(9'h0FF, 8, 4, 1'b1, 1'b0);
    repeat (4) @(posedge clk_i);
    cmp_bit(flag, 1'b1, "no wake flag");
    rd_chk(srb_pkg::OFS_BDC, 8'h40, "wake enable kept");
    bus(1'b0, srb_pkg::OFS_BUF, 8'h00, 4'h1);
    rd_chk(srb_pkg::OFS_STAT, 8'h00, "wake flag kept");
  endtask
  // Sync master single receive of a high data line
  task automatic t_sync();
    wr(srb_pkg::OFS_MODE, 8'h03);
    wr(srb_pkg::OFS_DLO, 8'h03);
    wr(srb_pkg::OFS_RSC, 8'hA0);
    wait_flag();
    rd_chk(srb_pkg::OFS_BUF, 8'hFF, "sync byte");
    rd_chk(srb_pkg::OFS_RSC, 8'h80, "single enable kept");
  endtask
  // Main sequence
  initial begin
    err_total = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_async();
    t_frame();
    t_overrun();
    t_addr();
    t_rates();
    t_wake();
    t_sync();
    stop_test();
  end
endmodule
